// File: common/switch_out_consts.svh
// constants of the switch output controller: register offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef SWITCH_OUT_CONSTS_SVH
`define SWITCH_OUT_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_ON_VAL 8'h04
`define ADDR_OFF_VAL 8'h08
`define ADDR_ON_DLY 8'h0C
`define ADDR_OFF_DLY 8'h10
`define ADDR_STATUS 8'h14

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_FUNC 2:0
`define CTRL_CLASS 5:4
`define CTRL_LIMSEL 11:8
`define CTRL_FALLBACK 13:12
`define CTRL_SOURCE 15:14
`define CTRL_INVERT 16

// ----------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------
`define ST_CLOSED 0
`define ST_ERROR 1
`define ST_LIMIT 2
`define ST_ON_PEND 3
`define ST_OFF_PEND 4

// ----------------------------------------------------------------
// synchronised event inputs, bit positions
// ----------------------------------------------------------------
`define EV_ALARM 0
`define EV_WARN 1
`define EV_ERROR 2
`define EV_BLK1 3
`define EV_BLK2 4
`define EV_W 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET 32'h0000_0000
`define VALUE_RESET 32'h0000_0000
`define DLY_RESET 10'h000
`define RDATA_RESET 32'h0000_0000

// ----------------------------------------------------------------
// delays: tenths of a second, 0.0 to 100.0 s
// ----------------------------------------------------------------
`define DLY_W 10
`define DLY_FIELD 9:0
`define DLY_MAX 10'h3E8
`define DLY_MAX_WORD 32'h0000_03E8
`define DLY_STEP_NS 100000000
`define CLK_PERIOD_NS 8

`endif

// File: common/switch_out_pkg.sv
// types of the switch output controller
// assumes switch_out_consts.svh on the include path
`include "switch_out_consts.svh"

package switch_out_pkg;

   // ----------------------------------------------------------------
   // setting encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {FUNC_OFF, FUNC_ON, FUNC_DIAG, FUNC_LIMIT, FUNC_DIGITAL} func_t;
   typedef enum logic [1:0] {CLASS_ALARM, CLASS_ALARM_WARN, CLASS_WARN} diag_class_t;
   typedef enum logic [1:0] {FB_ACTUAL, FB_OPEN, FB_CLOSED} fallback_t;
   typedef enum logic [1:0] {SRC_OFF, SRC_BLK1, SRC_BLK2} source_t;

   // ----------------------------------------------------------------
   // state of the top module
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] ctrl;
      logic signed [31:0] on_val;
      logic signed [31:0] off_val;
      logic [`DLY_W-1:0] on_dly;
      logic [`DLY_W-1:0] off_dly;
      logic lim_closed;
      logic closed;
      logic [31:0] rdata;
   } ctrl_state_t;

endpackage : switch_out_pkg

// File: logic/event_sync.sv
// three-stage synchroniser with agreement filter for a group of level inputs
// assumes inputs from outside the clk domain; output changes once stages 2 and 3 agree
`timescale 1ns/1ps

module event_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;
   logic [W-1:0] out_next;

   // ----------------------------------------------------------------
   // stages per bit
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.s1 = async_in;
         st_next.s2 = st_reg.s1;
         st_next.s3 = st_reg.s2;
      end
      st_next.out = out_next;
   end

   // output bit moves only once stages 2 and 3 agree
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign out_next[i] = (ce && (st_reg.s2[i] == st_reg.s3[i])) ? st_reg.s3[i] : st_reg.out[i];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.out;

endmodule : event_sync

// File: logic/delay_timer.sv
// delay timer counting tenth-second ticks while run is high
// assumes run is from the clk domain; done is combinational from state and inputs
`timescale 1ns/1ps

module delay_timer #(
   parameter int TICK_CYCLES = 12500000,
   parameter int DW = 10
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic run,
   input wire logic [DW-1:0] limit,
   output logic done
);

   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

   typedef struct packed {
      logic [PW-1:0] pre;
      logic [DW-1:0] tenths;
   } tmr_state_t;

   tmr_state_t st_reg;
   tmr_state_t st_next;

   assign done = run && (st_reg.tenths >= limit);

   // ----------------------------------------------------------------
   // counting
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         // [R15] cancel on drop
         if (!run || done) begin
            st_next = '0;
         end else if (st_reg.pre == PRE_LAST) begin
            st_next.pre = '0;
            st_next.tenths = st_reg.tenths + 1'b1;
         end else begin
            st_next.pre = st_reg.pre + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   cancel_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && !run) |=> (st_reg.tenths == '0 && st_reg.pre == '0)) // R15
      else $error("pending delay not cancelled");

endmodule : delay_timer

// File: logic/limit_switch_output_control.sv
// switch output controller: fixed, diagnostic, limit and digital-block modes
// assumes pv_values and clk-domain logic on clk; event inputs arrive asynchronously
//
// Contract
// [R1] off setting keeps the output open always
// [R2] on setting keeps the output closed always
// [R3] diagnostic mode: closed, open while an event of the chosen class exists
// [R4] class choice: alarm only, alarm or warning, warning only
// [R5] limit mode watches one chosen variable; off choice disables the check
// [R6] on above off: close above on value, open below off value
// [R7] on below off: close below on value, open above off value
// [R8] limit mode waits the switch-on delay, 0.0 to 100.0 s, before closing
// [R9] limit mode waits the switch-off delay, 0.0 to 100.0 s, before opening
// [R10] digital mode follows the chosen block: off, block one, block two
// [R11] limit or digital mode with error: actual, forced open or forced closed
// [R12] inversion swaps open and closed after all other settings
// [R13] present switch state is readable
// [R14] operator may use off and on settings to simulate the output
// [R15] a pending delay is dropped if its condition stops holding
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "switch_out_consts.svh"

module limit_switch_output_control #(
   parameter int NUM_PV = 12,
   parameter int TICK_CYCLES = `DLY_STEP_NS / `CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic [NUM_PV-1:0][31:0] pv_values,
   input wire logic alarm_in,
   input wire logic warning_in,
   input wire logic error_in,
   input wire logic binary_function_block_out_1,
   input wire logic binary_function_block_out_2,
   output logic switch_closed
);

   switch_out_pkg::ctrl_state_t st_reg;
   switch_out_pkg::ctrl_state_t st_next;

   // ----------------------------------------------------------------
   // event synchronisers
   // ----------------------------------------------------------------
   logic [`EV_W-1:0] ev_raw;
   logic [`EV_W-1:0] ev;

   always_comb begin
      ev_raw = '0;
      ev_raw[`EV_ALARM] = alarm_in;
      ev_raw[`EV_WARN] = warning_in;
      ev_raw[`EV_ERROR] = error_in;
      ev_raw[`EV_BLK1] = binary_function_block_out_1;
      ev_raw[`EV_BLK2] = binary_function_block_out_2;
   end

   event_sync #(
      .W(`EV_W)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .async_in(ev_raw),
      .sync_out(ev)
   );

   // ----------------------------------------------------------------
   // decoded settings
   // ----------------------------------------------------------------
   switch_out_pkg::func_t func;
   switch_out_pkg::diag_class_t dclass;
   switch_out_pkg::fallback_t fallback;
   switch_out_pkg::source_t source;
   logic [3:0] lim_sel;
   logic invert;
   logic err;

   assign func = switch_out_pkg::func_t'(st_reg.ctrl[`CTRL_FUNC]);
   assign dclass = switch_out_pkg::diag_class_t'(st_reg.ctrl[`CTRL_CLASS]);
   assign fallback = switch_out_pkg::fallback_t'(st_reg.ctrl[`CTRL_FALLBACK]);
   assign source = switch_out_pkg::source_t'(st_reg.ctrl[`CTRL_SOURCE]);
   assign lim_sel = st_reg.ctrl[`CTRL_LIMSEL];
   assign invert = st_reg.ctrl[`CTRL_INVERT];
   assign err = ev[`EV_ERROR];

   // ----------------------------------------------------------------
   // diagnostic event filter
   // ----------------------------------------------------------------
   logic diag_active;

   always_comb begin
      // [R4] class selection
      case (dclass)
         switch_out_pkg::CLASS_ALARM: diag_active = ev[`EV_ALARM];
         switch_out_pkg::CLASS_ALARM_WARN: diag_active = ev[`EV_ALARM] | ev[`EV_WARN];
         switch_out_pkg::CLASS_WARN: diag_active = ev[`EV_WARN];
         default: diag_active = ev[`EV_ALARM];
      endcase
   end

   // ----------------------------------------------------------------
   // limit variable selection and comparison
   // ----------------------------------------------------------------
   logic signed [31:0] pv_sel;
   logic lim_active;
   logic want_close;
   logic want_open;
   logic on_above;

   always_comb begin
      pv_sel = '0;
      // [R5] variable chosen
      for (int i = 0; i < NUM_PV; i++) begin
         if (lim_sel == 4'(i + 1)) begin
            pv_sel = $signed(pv_values[i]);
         end
      end
   end

   // [R5] off choice disables
   assign lim_active = (lim_sel != '0) && (int'(lim_sel) <= NUM_PV);
   assign on_above = (st_reg.on_val >= st_reg.off_val);

   always_comb begin
      if (on_above) begin
         // [R6] rising hysteresis
         want_close = pv_sel > st_reg.on_val;
         want_open = pv_sel < st_reg.off_val;
      end else begin
         // [R7] falling hysteresis
         want_close = pv_sel < st_reg.on_val;
         want_open = pv_sel > st_reg.off_val;
      end
   end

   // ----------------------------------------------------------------
   // switch-on and switch-off delays
   // ----------------------------------------------------------------
   logic on_run;
   logic off_run;
   logic on_done;
   logic off_done;

   // [R15] run only while the condition holds
   assign on_run = lim_active && !st_reg.lim_closed && want_close;
   assign off_run = lim_active && st_reg.lim_closed && want_open;

   // [R8] on delay
   delay_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .DW(`DLY_W)
   ) u_on_tmr (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .run(on_run),
      .limit(st_reg.on_dly),
      .done(on_done)
   );

   // [R9] off delay
   delay_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .DW(`DLY_W)
   ) u_off_tmr (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .run(off_run),
      .limit(st_reg.off_dly),
      .done(off_done)
   );

   logic lim_next;

   always_comb begin
      lim_next = st_reg.lim_closed;
      if (!lim_active) begin
         lim_next = 1'b1;
      end else if (on_run && on_done) begin
         // [R8] close after delay
         lim_next = 1'b1;
      end else if (off_run && off_done) begin
         // [R9] open after delay
         lim_next = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // output state
   // ----------------------------------------------------------------
   logic raw_closed;
   logic blk_closed;

   always_comb begin
      // [R10] block follower
      case (source)
         switch_out_pkg::SRC_BLK1: blk_closed = ev[`EV_BLK1];
         switch_out_pkg::SRC_BLK2: blk_closed = ev[`EV_BLK2];
         default: blk_closed = 1'b0;
      endcase
   end

   always_comb begin
      case (func)
         // [R1] always open
         switch_out_pkg::FUNC_OFF: raw_closed = 1'b0;
         // [R2] always closed
         switch_out_pkg::FUNC_ON: raw_closed = 1'b1;
         // [R3] open on event
         switch_out_pkg::FUNC_DIAG: raw_closed = !diag_active;
         switch_out_pkg::FUNC_LIMIT: raw_closed = lim_next;
         switch_out_pkg::FUNC_DIGITAL: raw_closed = blk_closed;
         default: raw_closed = 1'b0;
      endcase
      // [R11] error fallback
      if (err && (func == switch_out_pkg::FUNC_LIMIT || func == switch_out_pkg::FUNC_DIGITAL)) begin
         case (fallback)
            switch_out_pkg::FB_OPEN: raw_closed = 1'b0;
            switch_out_pkg::FB_CLOSED: raw_closed = 1'b1;
            default: raw_closed = raw_closed;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register port and state update
   // ----------------------------------------------------------------
   logic [`DLY_W-1:0] dly_wr;

   assign dly_wr = (wdata > `DLY_MAX_WORD) ? `DLY_MAX : wdata[`DLY_FIELD];

   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.lim_closed = lim_next;
         // [R12] inversion last
         st_next.closed = raw_closed ^ invert;
         st_next.rdata = `RDATA_RESET;
         if (wr_en) begin
            case (addr)
               `ADDR_CTRL: st_next.ctrl = wdata;
               `ADDR_ON_VAL: st_next.on_val = wdata;
               `ADDR_OFF_VAL: st_next.off_val = wdata;
               `ADDR_ON_DLY: st_next.on_dly = dly_wr;
               `ADDR_OFF_DLY: st_next.off_dly = dly_wr;
               default: st_next.ctrl = st_reg.ctrl;
            endcase
         end
         if (rd_en) begin
            case (addr)
               `ADDR_CTRL: st_next.rdata = st_reg.ctrl;
               `ADDR_ON_VAL: st_next.rdata = st_reg.on_val;
               `ADDR_OFF_VAL: st_next.rdata = st_reg.off_val;
               `ADDR_ON_DLY: st_next.rdata[`DLY_FIELD] = st_reg.on_dly;
               `ADDR_OFF_DLY: st_next.rdata[`DLY_FIELD] = st_reg.off_dly;
               `ADDR_STATUS: begin
                  // [R13] live state
                  st_next.rdata[`ST_CLOSED] = st_reg.closed;
                  st_next.rdata[`ST_ERROR] = err;
                  st_next.rdata[`ST_LIMIT] = st_reg.lim_closed;
                  st_next.rdata[`ST_ON_PEND] = on_run;
                  st_next.rdata[`ST_OFF_PEND] = off_run;
               end
               default: st_next.rdata = `RDATA_RESET;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg.ctrl <= `CTRL_RESET;
         st_reg.on_val <= `VALUE_RESET;
         st_reg.off_val <= `VALUE_RESET;
         st_reg.on_dly <= `DLY_RESET;
         st_reg.off_dly <= `DLY_RESET;
         st_reg.lim_closed <= 1'b1;
         st_reg.closed <= 1'b0;
         st_reg.rdata <= `RDATA_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign switch_closed = st_reg.closed;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence plain_s(switch_out_pkg::func_t f);
      ce && func == f && !invert;
   endsequence

   sequence lim_ok_s;
      plain_s(switch_out_pkg::FUNC_LIMIT) ##0 (!err && lim_active);
   endsequence

   off_open_a: assert property (plain_s(switch_out_pkg::FUNC_OFF) |=> !switch_closed) // R1
      else $error("off setting did not open output");

   on_closed_a: assert property (plain_s(switch_out_pkg::FUNC_ON) |=> switch_closed) // R2
      else $error("on setting did not close output");

   diag_open_a: assert property (plain_s(switch_out_pkg::FUNC_DIAG) |=> switch_closed == !$past(diag_active)) // R3
      else $error("diagnostic mode output wrong");

   diag_class_a: assert property (plain_s(switch_out_pkg::FUNC_DIAG)
      ##0 (dclass == switch_out_pkg::CLASS_WARN && ev[`EV_ALARM] && !ev[`EV_WARN])
      |=> switch_closed) // R4
      else $error("alarm opened warning-only output");

   rise_close_a: assert property (lim_ok_s ##0 (on_above && want_close
      && st_reg.on_dly == '0) |=> switch_closed) // R6
      else $error("rising limit did not close");

   fall_close_a: assert property (lim_ok_s ##0 (!on_above && want_close
      && st_reg.on_dly == '0) |=> switch_closed) // R7
      else $error("falling limit did not close");

   on_delay_a: assert property ((ce && lim_active && !st_reg.lim_closed && !on_done)
      |=> !st_reg.lim_closed) // R8
      else $error("closed before switch-on delay");

   off_delay_a: assert property ((ce && lim_active && st_reg.lim_closed && !off_done)
      |=> st_reg.lim_closed) // R9
      else $error("opened before switch-off delay");

   block_follow_a: assert property (plain_s(switch_out_pkg::FUNC_DIGITAL) ##0 (!err
      && source == switch_out_pkg::SRC_BLK1) |=> switch_closed == $past(ev[`EV_BLK1])) // R10
      else $error("output did not follow block one");

   fallback_open_a: assert property (plain_s(switch_out_pkg::FUNC_LIMIT) ##0 (err
      && fallback == switch_out_pkg::FB_OPEN) |=> !switch_closed) // R11
      else $error("error fallback did not open");

   invert_on_a: assert property ((ce && func == switch_out_pkg::FUNC_ON && invert)
      |=> !switch_closed) // R12
      else $error("inversion not applied");

   status_read_a: assert property ((ce && rd_en && addr == `ADDR_STATUS)
      |=> rdata[`ST_CLOSED] == $past(switch_closed)) // R13
      else $error("status read shows wrong state");

endmodule : limit_switch_output_control

// File: verification/load_circuit_model.sv
// model of the external load circuit switched by the output contact
// assumes the contact drives the load directly, no bounce
`timescale 1ns/1ps

module load_circuit_model (
   input wire logic switch_closed,
   output logic load_energised
);
   // ----------------------------------------------------------------
   // load follows the contact
   // ----------------------------------------------------------------
   assign load_energised = switch_closed;
endmodule : load_circuit_model

// File: verification/test_limit_switch_output_control.sv
// self-checking bench of the switch output controller
// assumes TICK_CYCLES of 4 so that one tenth of a second lasts 4 clocks
`timescale 1ns/1ps
`include "switch_out_consts.svh"

module test_limit_switch_output_control;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rdata;
   logic [11:0][31:0] pv_values = '0;
   logic alarm_in = 1'b0;
   logic warning_in = 1'b0;
   logic error_in = 1'b0;
   logic blk1 = 1'b0;
   logic blk2 = 1'b0;
   logic switch_closed;
   logic load_energised;
   int mismatches = 0;
   int comparisons = 0;

   always #4 clk = ~clk;

   limit_switch_output_control #(.NUM_PV(12), .TICK_CYCLES(4)) i_limit_switch_output_control (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .addr(addr),
      .wdata(wdata),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .rdata(rdata),
      .pv_values(pv_values),
      .alarm_in(alarm_in),
      .warning_in(warning_in),
      .error_in(error_in),
      .binary_function_block_out_1(blk1),
      .binary_function_block_out_2(blk2),
      .switch_closed(switch_closed)
   );

   load_circuit_model i_load_circuit_model (
      .switch_closed(switch_closed),
      .load_energised(load_energised)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic fail(input string msg);
      $display("[ERR] %0t %s", $time, msg);
      mismatches++;
   endtask : fail

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle

   task automatic chk(input logic exp);
      comparisons++;
      if (load_energised !== exp) begin
         fail("switch state wrong");
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      comparisons++;
      if ((rdata & mask) !== exp) begin
         fail("read data wrong");
      end
   endtask : rd

   task automatic setpv(input logic [31:0] v);
      @(posedge clk);
      pv_values[0] <= v;
   endtask : setpv

   function automatic logic [31:0] mk(input logic [2:0] f, input logic [1:0] c,
      input logic [3:0] s, input logic [1:0] fb, input logic [1:0] src, input logic inv);
      mk = {15'h0000, inv, src, fb, s, 2'h0, c, 1'h0, f};
   endfunction : mk

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic fixed_modes;
      wr(`ADDR_CTRL, mk(3'h1, 2'h0, 4'h0, 2'h0, 2'h0, 1'b0));
      alarm_in <= 1'b1;
      idle(8);
      chk(1'b1);
      rd(`ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
      wr(`ADDR_STATUS, 32'h0000_0000);
      rd(`ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
      wr(`ADDR_CTRL, mk(3'h1, 2'h0, 4'h0, 2'h0, 2'h0, 1'b1));
      idle(3);
      chk(1'b0);
      wr(`ADDR_CTRL, mk(3'h0, 2'h0, 4'h0, 2'h0, 2'h0, 1'b1));
      idle(3);
      chk(1'b1);
      wr(`ADDR_CTRL, mk(3'h0, 2'h0, 4'h0, 2'h0, 2'h0, 1'b0));
      idle(3);
      chk(1'b0);
      rd(`ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
      rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
      // clock enable low: write strobe ignored, state frozen
      @(posedge clk);
      ce <= 1'b0;
      wr(`ADDR_CTRL, mk(3'h1, 2'h0, 4'h0, 2'h0, 2'h0, 1'b0));
      idle(3);
      chk(1'b0);
      @(posedge clk);
      ce <= 1'b1;
      alarm_in <= 1'b0;
      idle(3);
      chk(1'b0);
   endtask : fixed_modes

   task automatic diag_modes;
      logic [1:0] ev;
      for (int c = 0; c < 3; c++) begin
         wr(`ADDR_CTRL, mk(3'h2, c[1:0], 4'h0, 2'h0, 2'h0, 1'b0));
         for (int e = 0; e < 3; e++) begin
            ev = (e == 0) ? 2'b00 : (e == 1) ? 2'b01 : 2'b10;
            @(posedge clk);
            alarm_in <= ev[0];
            warning_in <= ev[1];
            idle(8);
            chk(!((c != 2 && ev[0]) || (c != 0 && ev[1])));
         end
      end
      @(posedge clk);
      alarm_in <= 1'b0;
      warning_in <= 1'b0;
      idle(8);
   endtask : diag_modes

   task automatic limit_modes;
      wr(`ADDR_ON_VAL, 32'd100);
      wr(`ADDR_OFF_VAL, 32'd50);
      setpv(32'd70);
      wr(`ADDR_CTRL, mk(3'h3, 2'h0, 4'h1, 2'h0, 2'h0, 1'b0));
      setpv(32'd30);
      idle(3);
      chk(1'b0);
      setpv(32'd70);
      idle(3);
      chk(1'b0);
      setpv(32'd120);
      idle(3);
      chk(1'b1);
      setpv(-32'sd5);
      idle(3);
      chk(1'b0);
      setpv(32'd120);
      wr(`ADDR_ON_DLY, 32'd5);
      wr(`ADDR_OFF_DLY, 32'd3);
      setpv(32'd30);
      idle(6);
      chk(1'b1);
      idle(14);
      chk(1'b0);
      setpv(32'd120);
      idle(10);
      setpv(32'd70);
      idle(30);
      chk(1'b0);
      setpv(32'd120);
      idle(12);
      chk(1'b0);
      idle(16);
      chk(1'b1);
      wr(`ADDR_ON_DLY, 32'd0);
      wr(`ADDR_OFF_DLY, 32'd0);
      wr(`ADDR_ON_VAL, 32'd50);
      wr(`ADDR_OFF_VAL, 32'd100);
      setpv(32'd30);
      idle(3);
      chk(1'b1);
      setpv(32'd120);
      idle(3);
      chk(1'b0);
      setpv(32'd70);
      idle(3);
      chk(1'b0);
      wr(`ADDR_CTRL, mk(3'h3, 2'h0, 4'h0, 2'h0, 2'h0, 1'b0));
      idle(3);
      chk(1'b1);
      rd(`ADDR_ON_VAL, 32'hFFFF_FFFF, 32'h0000_0032);
      wr(`ADDR_OFF_DLY, 32'h0000_0FFF);
      rd(`ADDR_OFF_DLY, 32'hFFFF_FFFF, `DLY_MAX_WORD);
   endtask : limit_modes

   task automatic block_and_fallback;
      @(posedge clk);
      blk1 <= 1'b1;
      for (int s = 0; s < 3; s++) begin
         wr(`ADDR_CTRL, mk(3'h4, 2'h0, 4'h0, 2'h0, s[1:0], 1'b0));
         idle(8);
         chk(s == 1);
      end
      @(posedge clk);
      error_in <= 1'b1;
      for (int f = 0; f < 3; f++) begin
         wr(`ADDR_CTRL, mk(3'h3, 2'h0, 4'h0, f[1:0], 2'h0, 1'b0));
         idle(8);
         chk(f != 1);
         wr(`ADDR_CTRL, mk(3'h4, 2'h0, 4'h0, f[1:0], 2'h2, 1'b0));
         idle(3);
         chk(f == 2);
      end
      rd(`ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
      @(posedge clk);
      error_in <= 1'b0;
      blk1 <= 1'b0;
   endtask : block_and_fallback

   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      idle(1);
      chk(1'b0);
      rd(`ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      fixed_modes();
      diag_modes();
      limit_modes();
      block_and_fallback();
      finish_test();
   end

   initial begin
      #800000;
      fail("run did not end");
      finish_test();
   end
endmodule : test_limit_switch_output_control
